// file: hdl/pmu_pkg.sv
package pmu_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// serial target identity and register window
	localparam logic [6:0] TARGET_ADDR = 7'h55;
	localparam int         NUM_REGS    = 17;
	localparam logic [7:0] REG_FIRST   = 8'h07;
	localparam logic [7:0] REG_LAST    = 8'h17;

	localparam logic [7:0] LINREG_G_VOLTAGE = 8'h07;
	localparam logic [7:0] CHARGER_CFG_A    = 8'h08;
	localparam logic [7:0] CHARGER_CFG_B    = 8'h09;
	localparam logic [7:0] CHARGER_STATUS_A = 8'h0A;
	localparam logic [7:0] CHARGER_CFG_C    = 8'h0B;
	localparam logic [7:0] LINREG_C_CTRL    = 8'h0C;
	localparam logic [7:0] LINREG_E_CTRL    = 8'h0D;
	localparam logic [7:0] LINREG_G_CTRL    = 8'h0E;
	localparam logic [7:0] LINREG_A_CTRL    = 8'h0F;
	localparam logic [7:0] LINREG_D_CTRL    = 8'h10;
	localparam logic [7:0] LINREG_F_CTRL    = 8'h11;
	localparam logic [7:0] LINREG_H_CTRL    = 8'h12;
	localparam logic [7:0] LINREG_B_CTRL    = 8'h13;
	localparam logic [7:0] BUCK_VOLTAGE     = 8'h14;
	localparam logic [7:0] BUCK_CFG_A       = 8'h15;
	localparam logic [7:0] BUCK_STATUS      = 8'h16;
	localparam logic [7:0] BUCK_CFG_B       = 8'h17;

	// index 0 is offset 07h, index 16 is offset 17h
	localparam logic [16:0][7:0] RO_MASK = {
		8'hFE, 8'hFF, 8'hFE, 8'h80, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40,
		8'h5F, 8'h40, 8'h40, 8'hFE, 8'hFF, 8'h3F, 8'h08, 8'h80};
	localparam logic [16:0][7:0] VOLT_MASK = {
		8'h00, 8'h00, 8'h00, 8'h7F, 8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h1F,
		8'h00, 8'h1F, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h07, 8'h7F};
	localparam logic [16:0][7:0] FIXED_RESET = {
		8'h01, 8'h00, 8'h00, 8'h00, 8'h80, 8'hA0, 8'h80, 8'h80, 8'hA0,
		8'hA0, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	////////////////////////////////////////////////////////////////////////////////
	// timing at the 10 MHz system clock
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_PERIOD_NS = 2500;
	// a quarter of the least serial clock period, rounded up
	localparam int QTR_CYCLES    = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

	////////////////////////////////////////////////////////////////////////////////
	// controller register map (byte addresses)
	localparam logic [11:0] CTRL_OFS       = 12'h000;
	localparam logic [11:0] REGADDR_OFS    = 12'h004;
	localparam logic [11:0] WDATA_OFS      = 12'h008;
	localparam logic [11:0] STATUS_OFS     = 12'h00C;
	localparam int          CTRL_GO_BIT    = 0;
	localparam int          CTRL_READ_BIT  = 1;
	localparam int          STAT_BUSY_BIT  = 0;
	localparam int          STAT_NACK_BIT  = 1;
	localparam int          STAT_RDATA_LSB = 8;

	function automatic logic pmu_reg_hit(input logic [7:0] addr);
		return (addr >= REG_FIRST) && (addr <= REG_LAST);
	endfunction

	function automatic logic [4:0] pmu_reg_index(input logic [7:0] addr);
		logic [7:0] d;
		d = addr - REG_FIRST;
		return d[4:0];
	endfunction

endpackage

// file: hdl/pmu_link_if.sv
`timescale 1ns/1ns
interface pmu_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// open drain with pull-up: low whenever an enabled driver pulls low
	assign scl = ~(host_scl_oe & ~host_scl_o);
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);
endinterface

// file: hdl/pmu_sync2.sv
`timescale 1ns/1ns
module pmu_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output      logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// idle bus level is high, so reset to ones avoids a false start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= '1;
			sync_out <= '1;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// file: hdl/pmu_i2c_target.sv
// Behaviour
// - start, address+dir, regaddr, data, acks, stop
// - all three fields go MSB first
// - data changes low, sampled on clock rise
// - write takes effect at last data bit
// - host keeps to the documented map
// - read-only bits show status, ignore writes
// - voltage bits reset from factory option
// - target only, answers address 1010101
// - host uses single-byte writes and reads
`timescale 1ns/1ns
module pmu_i2c_target #(
	parameter logic [16:0][7:0] VOLT_OPT = '0
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	pmu_link_if.dev               link,
	input  wire logic [16:0][7:0] status_in,
	output      logic [16:0][7:0] cfg_out,
	output      logic             cfg_wr,
	output      logic [7:0]       cfg_wr_addr,
	output      logic             session_active
);
	typedef enum logic [9:0] {
		T_IDLE   = 10'b0000000001,
		T_ADDR   = 10'b0000000010,
		T_ACK_A  = 10'b0000000100,
		T_REG    = 10'b0000001000,
		T_ACK_R  = 10'b0000010000,
		T_WDATA  = 10'b0000100000,
		T_ACK_W  = 10'b0001000000,
		T_RDATA  = 10'b0010000000,
		T_ACK_RD = 10'b0100000000,
		T_DONE   = 10'b1000000000
	} pmu_tgt_state_t;

	pmu_tgt_state_t state;
	logic           scl_s;
	logic           sda_s;
	logic           scl_q;
	logic           sda_q;
	logic [2:0]     cnt;
	logic           full;
	logic [7:0]     shift;
	logic [7:0]     byte_in;
	logic           rd_dir;
	logic [7:0]     reg_addr;
	logic [7:0]     tx;
	logic           drive_low;
	logic           counting;
	logic [7:0]     rd_val;
	logic [4:0]     rd_idx;
	logic [4:0]     wr_idx;

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling and bus events

	pmu_sync2 #(.WIDTH(2)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({link.scl, link.sda}),
		.sync_out ({scl_s, sda_s})
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
		end
	end

	wire scl_rise   = scl_s & ~scl_q;
	wire scl_fall   = ~scl_s & scl_q;
	wire start_cond = scl_s & scl_q & sda_q & ~sda_s;
	wire stop_cond  = scl_s & scl_q & ~sda_q & sda_s;

	assign byte_in  = {shift[6:0], sda_s};
	assign counting = (state == T_ADDR) || (state == T_REG) ||
	                  (state == T_WDATA) || (state == T_RDATA);
	assign rd_idx   = pmu_pkg::pmu_reg_index(reg_addr);
	assign wr_idx   = rd_idx;

	// unmapped addresses read as zero
	always_comb begin
		rd_val = 8'h00;
		if (pmu_pkg::pmu_reg_hit(reg_addr)) begin
			rd_val = (cfg_out[rd_idx] & ~pmu_pkg::RO_MASK[rd_idx]) |
			         (status_in[rd_idx] & pmu_pkg::RO_MASK[rd_idx]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bit receiver: counts rises only inside byte phases, acks are not counted

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt   <= 3'h0;
			full  <= 1'b0;
			shift <= 8'h00;
		end else if (start_cond || stop_cond) begin
			cnt  <= 3'h0;
			full <= 1'b0;
		end else if (scl_rise && counting) begin
			shift <= byte_in;
			cnt   <= cnt + 3'h1;
			full  <= (cnt == 3'h7);
		end else if (scl_fall) begin
			full <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// session sequencer; the data line only moves on a seen clock fall

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= T_IDLE;
			rd_dir    <= 1'b0;
			reg_addr  <= 8'h00;
			tx        <= 8'h00;
			drive_low <= 1'b0;
		end else if (start_cond) begin
			state     <= T_ADDR;
			drive_low <= 1'b0;
		end else if (stop_cond) begin
			state     <= T_IDLE;
			drive_low <= 1'b0;
		end else if (scl_fall) begin
			case (state)
				T_ADDR: begin
					if (full && shift[7:1] == pmu_pkg::TARGET_ADDR) begin
						rd_dir    <= shift[0];
						state     <= T_ACK_A;
						drive_low <= 1'b1;
					end else if (full) begin
						state <= T_DONE;
					end
				end
				T_ACK_A: begin
					state     <= T_REG;
					drive_low <= 1'b0;
				end
				T_REG: begin
					if (full) begin
						reg_addr  <= shift;
						state     <= T_ACK_R;
						drive_low <= 1'b1;
					end
				end
				T_ACK_R: begin
					if (rd_dir) begin
						tx        <= rd_val;
						drive_low <= ~rd_val[7];
						state     <= T_RDATA;
					end else begin
						drive_low <= 1'b0;
						state     <= T_WDATA;
					end
				end
				T_WDATA: begin
					if (full) begin
						state     <= T_ACK_W;
						drive_low <= 1'b1;
					end
				end
				T_ACK_W: begin
					state     <= T_DONE;
					drive_low <= 1'b0;
				end
				T_RDATA: begin
					if (full) begin
						state     <= T_ACK_RD;
						drive_low <= 1'b0;
					end else begin
						drive_low <= ~tx[3'h7 - cnt];
					end
				end
				T_ACK_RD: begin
					state <= T_DONE;
				end
				default: begin
					drive_low <= 1'b0;
				end
			endcase
		end
	end

	// only an acknowledge or a zero read bit ever pulls the line
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = drive_low;
	assign session_active  = (state != T_IDLE) && (state != T_DONE);

	////////////////////////////////////////////////////////////////////////////////
	// register file; only the writable bits are stored

	wire wr_hit = (state == T_WDATA) && scl_rise && (cnt == 3'h7) &&
	              pmu_pkg::pmu_reg_hit(reg_addr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < pmu_pkg::NUM_REGS; i++) begin
				cfg_out[i] <= pmu_pkg::FIXED_RESET[i] |
				              (VOLT_OPT[i] & pmu_pkg::VOLT_MASK[i]);
			end
		end else if (wr_hit) begin
			cfg_out[wr_idx] <= byte_in & ~pmu_pkg::RO_MASK[wr_idx];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_wr      <= 1'b0;
			cfg_wr_addr <= 8'h00;
		end else begin
			cfg_wr <= wr_hit;
			if (wr_hit) begin
				cfg_wr_addr <= reg_addr;
			end
		end
	end
endmodule

// file: hdl/pmu_i2c_host.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module pmu_i2c_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output      logic [31:0] prdata,
	output      logic        pready,
	output      logic        pslverr,
	pmu_link_if.host         link
);
	typedef enum logic [3:0] {
		H_IDLE  = 4'b0001,
		H_START = 4'b0010,
		H_BITS  = 4'b0100,
		H_STOP  = 4'b1000
	} pmu_host_state_t;

	localparam logic [3:0] QTR_LOAD = 4'(pmu_pkg::QTR_CYCLES - 1);

	pmu_host_state_t state;
	logic            sda_s;
	logic [3:0]      qcnt;
	logic [1:0]      qtr;
	logic [3:0]      bitn;
	logic [1:0]      byten;
	logic            op_read;
	logic [7:0]      reg_addr;
	logic [7:0]      wdata;
	logic [7:0]      rdata;
	logic            busy;
	logic            nack;
	logic            scl_low;
	logic            sda_low;
	logic            next_scl_low;
	logic            next_sda_low;
	logic            host_bit;
	logic [7:0]      cur_byte;
	logic            mapped;

	pmu_sync2 #(.WIDTH(1)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (link.sda),
		.sync_out (sda_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// apb slave, zero wait states

	wire acc    = psel & penable;
	wire launch = acc && pwrite && (paddr == pmu_pkg::CTRL_OFS) &&
	              pwdata[pmu_pkg::CTRL_GO_BIT] && !busy;

	assign mapped  = (paddr == pmu_pkg::CTRL_OFS) || (paddr == pmu_pkg::REGADDR_OFS) ||
	                 (paddr == pmu_pkg::WDATA_OFS) || (paddr == pmu_pkg::STATUS_OFS);
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= 32'h0000_0000;
			case (paddr)
				pmu_pkg::CTRL_OFS:    prdata[pmu_pkg::CTRL_READ_BIT] <= op_read;
				pmu_pkg::REGADDR_OFS: prdata[7:0] <= reg_addr;
				pmu_pkg::WDATA_OFS:   prdata[7:0] <= wdata;
				pmu_pkg::STATUS_OFS: begin
					prdata[pmu_pkg::STAT_BUSY_BIT] <= busy;
					prdata[pmu_pkg::STAT_NACK_BIT] <= nack;
					prdata[pmu_pkg::STAT_RDATA_LSB +: 8] <= rdata;
				end
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// settings change only while idle so a session sees stable fields
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_read  <= 1'b0;
			reg_addr <= 8'h00;
			wdata    <= 8'h00;
		end else if (acc && pwrite && !busy) begin
			case (paddr)
				pmu_pkg::CTRL_OFS:    op_read <= pwdata[pmu_pkg::CTRL_READ_BIT];
				pmu_pkg::REGADDR_OFS: reg_addr <= pwdata[7:0];
				pmu_pkg::WDATA_OFS:   wdata <= pwdata[7:0];
				default:              op_read <= op_read;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// session engine: each bit is four quarters, clock low for the first two

	wire tick    = (qcnt == 4'h0);
	wire end_bit = tick && (qtr == 2'h3);
	wire data_rd = op_read && (byten == 2'h2);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= H_IDLE;
			qcnt  <= 4'h0;
			qtr   <= 2'h0;
			bitn  <= 4'h0;
			byten <= 2'h0;
			busy  <= 1'b0;
			nack  <= 1'b0;
			rdata <= 8'h00;
		end else if (state == H_IDLE) begin
			if (launch) begin
				state <= H_START;
				qcnt  <= QTR_LOAD;
				qtr   <= 2'h0;
				busy  <= 1'b1;
				nack  <= 1'b0;
			end
		end else if (tick) begin
			qcnt <= QTR_LOAD;
			qtr  <= qtr + 2'h1;
			if (end_bit) begin
				case (state)
					H_START: begin
						state <= H_BITS;
						bitn  <= 4'h0;
						byten <= 2'h0;
					end
					H_BITS: begin
						if (bitn == 4'h8) begin
							bitn <= 4'h0;
							if (!data_rd && sda_s) begin
								nack  <= 1'b1;
								state <= H_STOP;
							end else if (byten == 2'h2) begin
								state <= H_STOP;
							end else begin
								byten <= byten + 2'h1;
							end
						end else begin
							bitn <= bitn + 4'h1;
							if (data_rd) begin
								rdata <= {rdata[6:0], sda_s};
							end
						end
					end
					H_STOP: begin
						state <= H_IDLE;
						busy  <= 1'b0;
					end
					default: state <= H_IDLE;
				endcase
			end
		end else begin
			qcnt <= qcnt - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// line drive

	always_comb begin
		case (byten)
			2'h0:    cur_byte = {pmu_pkg::TARGET_ADDR, op_read};
			2'h1:    cur_byte = reg_addr;
			default: cur_byte = op_read ? 8'hFF : wdata;
		endcase
		if (bitn == 4'h8) begin
			host_bit = !data_rd;
		end else begin
			host_bit = cur_byte[3'h7 - bitn[2:0]];
		end
	end

	always_comb begin
		next_scl_low = 1'b0;
		next_sda_low = sda_low;
		case (state)
			H_START: begin
				next_sda_low = (qtr >= 2'h2);
			end
			H_BITS: begin
				next_scl_low = (qtr < 2'h2);
				// hold through the first low quarter
				if (qtr != 2'h0) begin
					next_sda_low = ~host_bit;
				end
			end
			H_STOP: begin
				next_scl_low = (qtr < 2'h2);
				if (qtr != 2'h0) begin
					next_sda_low = (qtr != 2'h3);
				end
			end
			default: next_sda_low = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_low <= 1'b0;
			sda_low <= 1'b0;
		end else begin
			scl_low <= next_scl_low;
			sda_low <= next_sda_low;
		end
	end

	assign link.host_scl_o  = 1'b0;
	assign link.host_scl_oe = scl_low;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = sda_low;
endmodule

// file: tb/pmu_link_properties.sv
`timescale 1ns/1ns
module pmu_link_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic host_scl_oe,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q;
	logic       sda_q;
	logic [4:0] cnt;
	logic [6:0] shf;
	logic       adr_ok;
	logic       rd;
	wire        rise  = scl & ~scl_q;
	wire        start = scl & scl_q & sda_q & ~sda;
	wire        stop  = scl & scl_q & ~sda_q & sda;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////////////////////////
	// idle lines read high, so no false start right after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 5'h00;
			shf <= 7'h00;
		end else if (start) begin
			cnt <= 5'h00;
		end else if (rise) begin
			cnt <= cnt + 5'h01;
			shf <= {shf[5:0], sda};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adr_ok <= 1'b0;
			rd     <= 1'b0;
		end else if (start) begin
			adr_ok <= 1'b0;
		end else if (rise && cnt == 5'h07) begin
			adr_ok <= (shf == 7'h55);
			rd     <= sda;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_start_hold: assert property (start |=> scl [*8])
		else $error("clock fell too soon after start");
	a_stop_idle: assert property (stop |=> (scl && sda) [*8])
		else $error("bus not idle after stop");
	a_host_sda_edge: assert property ($changed(host_sda_oe) && scl && scl_q |-> start || stop)
		else $error("host data moved while clock high");
	a_dev_sda_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target data moved while clock high");
	a_addr_ack: assert property (rise && cnt == 5'h08 |-> dev_sda_oe == adr_ok)
		else $error("address acknowledge wrong");
	a_dev_slots: assert property (rise && dev_sda_oe |-> adr_ok && (cnt == 5'h08 ||
		cnt == 5'h11 || (rd && cnt >= 5'h12 && cnt <= 5'h19) || (!rd && cnt == 5'h1A)))
		else $error("target drove outside its slots");
	a_reg_ack: assert property (rise && cnt == 5'h11 && adr_ok |-> dev_sda_oe)
		else $error("register address not acknowledged");
	a_data_ack: assert property (rise && cnt == 5'h1A && adr_ok && !rd |-> dev_sda_oe)
		else $error("write data not acknowledged");
	a_host_rd_ack: assert property (rise && cnt == 5'h1A && rd |-> host_sda_oe && !dev_sda_oe)
		else $error("read data acknowledge wrong");
	a_host_quiet: assert property (rise && rd && adr_ok && cnt >= 5'h12 && cnt <= 5'h19
		|-> !host_sda_oe)
		else $error("host drove during read data");
	a_dev_release: assert property ($rose(dev_sda_oe) |-> ##[1:300] !dev_sda_oe)
		else $error("target held data line too long");
	a_scl_low_time: assert property ($rose(host_scl_oe) |=> host_scl_oe [*8])
		else $error("clock low phase too short");

	c_read: cover property (rise && cnt == 5'h1A && rd);
	c_write: cover property (rise && cnt == 5'h1A && !rd && adr_ok);
	c_stop: cover property (stop);
endmodule

// file: tb/pmu_i2c_register_slave_test.sv
`timescale 1ns/1ns
module pmu_i2c_register_slave_test;
	localparam logic [16:0][7:0] VOPT = {17{8'h5A}};
	logic             pclk        = 1'b0;
	logic             presetn     = 1'b0;
	logic [11:0]      paddr       = 12'h000;
	logic             psel        = 1'b0;
	logic             penable     = 1'b0;
	logic             pwrite      = 1'b0;
	logic [31:0]      pwdata      = 32'h0;
	logic [31:0]      prdata;
	logic             pready;
	logic             pslverr;
	logic [16:0][7:0] st_in       = '0;
	logic [16:0][7:0] cfg;
	logic [16:0][7:0] cfg2;
	logic [16:0][7:0] mdl;
	logic [15:0]      seed        = 16'h001E;
	int               err_total   = 0;
	int               comparisons = 0;
	int               cyc         = 0;
	logic             wr_seen;
	logic [7:0]       wr_addr;
	logic             act;
	int               wr_cnt      = 0;

	pmu_link_if link ();
	pmu_link_if link2 ();
	pmu_i2c_host u_pmu_i2c_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	pmu_i2c_target #(.VOLT_OPT(VOPT)) u_pmu_i2c_target (.pclk(pclk), .presetn(presetn),
		.link(link), .status_in(st_in), .cfg_out(cfg), .cfg_wr(wr_seen),
		.cfg_wr_addr(wr_addr), .session_active(act));
	// second target faces the bench's own bit driver, which may break the rules
	pmu_i2c_target #(.VOLT_OPT(VOPT)) u_pmu_i2c_target_b (.pclk(pclk), .presetn(presetn),
		.link(link2), .status_in(st_in), .cfg_out(cfg2), .cfg_wr(), .cfg_wr_addr(),
		.session_active());
	pmu_link_properties u_pmu_link_properties (.pclk(pclk), .presetn(presetn),
		.host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
		.dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

	always #50 pclk = ~pclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		if (wr_seen) begin
			wr_cnt <= wr_cnt + 1;
		end
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_total++;
			end_sim;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [7:0] rd_exp(input logic [7:0] a);
		if (a < 8'h07 || a > 8'h17) return 8'h00;
		return mdl[a - 8'h07] | (st_in[a - 8'h07] & pmu_pkg::RO_MASK[a - 8'h07]);
	endfunction

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next call never re-drives psel in this time step
		@(posedge pclk);
	endtask

	task automatic sess(input logic r, input logic [7:0] ra, input logic [7:0] wd,
		output logic [31:0] s);
		logic e;
		apb(1'b1, pmu_pkg::REGADDR_OFS, {24'h0, ra}, s, e);
		apb(1'b1, pmu_pkg::WDATA_OFS, {24'h0, wd}, s, e);
		apb(1'b1, pmu_pkg::CTRL_OFS, {30'h0, r, 1'b1}, s, e);
		// refused while busy, so the session must keep ra
		apb(1'b1, pmu_pkg::REGADDR_OFS, {24'h0, ~ra}, s, e);
		s = 32'h1;
		while (s[0] !== 1'b0) apb(1'b0, pmu_pkg::STATUS_OFS, 32'h0, s, e);
	endtask

	task automatic bit2(input logic v, output logic q);
		link2.host_scl_oe <= 1'b1;
		repeat (7) @(posedge pclk);
		link2.host_sda_oe <= ~v;
		repeat (7) @(posedge pclk);
		link2.host_scl_oe <= 1'b0;
		repeat (14) @(posedge pclk);
		q = link2.sda;
	endtask

	task automatic go2(input logic [7:0] ad, input logic [7:0] wd, input logic ok);
		logic q;
		logic [7:0] old;
		old = cfg2[13];
		link2.host_sda_oe <= 1'b1;
		repeat (14) @(posedge pclk);
		for (int i = 7; i >= 0; i--) bit2(ad[i], q);
		bit2(1'b1, q);
		chk(q, !ok);
		for (int i = 7; i >= 0; i--) bit2(pmu_pkg::BUCK_VOLTAGE[i], q);
		bit2(1'b1, q);
		for (int i = 7; i >= 1; i--) bit2(wd[i], q);
		chk(cfg2[13], old);
		bit2(wd[0], q);
		chk(cfg2[13], ok ? (wd & ~pmu_pkg::RO_MASK[13]) : old);
		bit2(1'b1, q);
		bit2(1'b0, q);
		link2.host_sda_oe <= 1'b0;
		repeat (14) @(posedge pclk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] s;
		logic        e;
		logic [7:0]  a;
		logic [7:0]  d;
		logic [7:0]  corner [8];
		// only mapped addresses: others may hold trim settings
		corner = '{8'h07, 8'h17, 8'h08, 8'h0E, 8'h14, 8'h15, 8'h0A, 8'h16};
		link2.host_scl_o = 1'b0;
		link2.host_sda_o = 1'b0;
		link2.host_scl_oe = 1'b0;
		link2.host_sda_oe = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 17; i++) begin
			mdl[i] = (pmu_pkg::FIXED_RESET[i] | (VOPT[i] & pmu_pkg::VOLT_MASK[i]))
				& ~pmu_pkg::RO_MASK[i];
			chk(cfg[i], mdl[i]);
		end
		apb(1'b1, 12'h010, 32'hFFFF_FFFF, s, e);
		chk(e, 1'b1);
		apb(1'b0, 12'h010, 32'h0, s, e);
		chk({s[31:1], e}, 32'h1);
		go2(8'hA8, 8'h3C, 1'b0);
		go2(8'hAA, 8'hC3, 1'b1);
		for (int n = 0; n < 30; n++) begin
			seed = lfsr(seed);
			a = (n < 8) ? corner[n] : pmu_pkg::REG_FIRST + {3'b000, seed[4:0] % 5'h11};
			d = seed[15:8];
			sess(1'b0, a, d, s);
			chk(s[1], 1'b0);
			if (a >= 8'h07 && a <= 8'h17) mdl[a - 8'h07] = d & ~pmu_pkg::RO_MASK[a - 8'h07];
			for (int i = 0; i < 17; i++) chk(cfg[i], mdl[i]);
			chk(wr_cnt, n + 1);
			chk(wr_addr, a);
			seed = lfsr(seed);
			st_in[n % 17] <= seed[7:0];
			sess(1'b1, a, ~d, s);
			chk(s[15:8], rd_exp(a));
			chk(s[1], 1'b0);
			chk(act, 1'b0);
		end
		end_sim;
	end
endmodule
